// File: verilog/spf_defines.vh
// Register offsets, field positions and reset values of the serial port slice.
// Included by the design file; holds definitions only.
`ifndef SPF_DEFINES_VH
`define SPF_DEFINES_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SPF_OFS_CTRL 5'h00
`define SPF_OFS_TXDATA 5'h04
`define SPF_OFS_RXDATA 5'h08
`define SPF_OFS_STATUS 5'h0c
`define SPF_OFS_BAUD 5'h10
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SPF_BIT_FRAMED 31
`define SPF_BIT_AUDIO 30
`define SPF_BIT_ON 15
`define SPF_BIT_WIDE 11
`define SPF_BIT_MID 10
`define SPF_BIT_PHASE 9
`define SPF_BIT_CKE 8
`define SPF_BIT_SSUSE 7
`define SPF_BIT_POL 6
`define SPF_BIT_MASTER 5
`define SPF_CTRL_MASK 32'hc0008fe0
`define SPF_CTRL_RESET 32'h00000000
`define SPF_BAUD_RESET 16'h0001
// ----------------------------------------
// Status register fields
// ----------------------------------------
`define SPF_ST_TXEMPTY 0
`define SPF_ST_TXFULL 1
`define SPF_ST_RXFULL 2
`define SPF_ST_RXOVF 3
`define SPF_ST_BUSY 4
`define SPF_ST_WS 5
// ----------------------------------------
// Bus answers
// ----------------------------------------
`define SPF_RESP_OKAY 2'b00
`define SPF_RESP_SLVERR 2'b10
`endif

// File: verilog/spf_serial_port.v
// Serial port with frame/word width configuration, AXI4-Lite registers and a
// transmit FIFO. Assumes one clock aclk; serial pins arrive asynchronously.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "spf_defines.vh"

// ----------------------------------------
// Transmit FIFO
// ----------------------------------------
module spf_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire aclk,
	input wire aresetn,
	input wire flush,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_ptr;
	reg [AW:0] rd_ptr;
	wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data = mem[rd_ptr[AW-1:0]];
	// Storage has no reset; only pointers define emptiness
	always @(posedge aclk) begin
		if (in_valid && !full)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end
	// Pointers with one extra wrap bit give honest full and empty
	always @(posedge aclk) begin
		if (!aresetn || flush) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full)
				wr_ptr <= wr_ptr + 1'b1;
			if (out_ready && out_valid)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// Functional notes
// - Audio, both width bits: 24-bit samples, 32-bit words, channels, 64-bit frames.
// - Audio: mid bit gives 16-bit in 32-bit channels; none gives 16/16.
// - Plain serial: wide bit 32-bit, only mid 16-bit, none 8-bit words.
// - Master samples input at bit end when phase bit is 1, else middle.
// - Slave ignores phase bit and always samples at bit middle.
// - Edge bit 1 changes output active-to-idle unless framed; 0 changes idle-to-active.
// - Width bits are writable only while the module is off.
// - Audio operation forces clock polarity to idle high.
// - Slave-select bit set makes slave use the active-low select pin.
// - Polarity 1 idles clock high; 0 idles it low.
// - Master bit 1 selects master role, 0 slave role.
// - Width select bits sit at control bits eleven and ten.
// - Module enable bit turns the port on or off.
module spf_serial_port (
	input wire aclk,
	input wire aresetn,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire sclk_i,
	output reg sclk_o,
	output reg sclk_oe_n,
	input wire sdi,
	output reg sdo,
	input wire slave_select_pin_n,
	output reg word_select
);
	reg [31:0] ctrl;
	reg [15:0] baud;
	reg [31:0] rx_data;
	reg rx_full;
	reg rx_ovf;
	reg aw_held;
	reg w_held;
	reg [4:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg [2:0] sclk_s;
	reg [1:0] sdi_s;
	reg [1:0] ss_s;
	reg busy;
	reg [6:0] t_cnt;
	reg [5:0] bit_cnt;
	reg [15:0] div_cnt;
	reg [31:0] tx_sh;
	reg [31:0] rx_sh;
	reg sclk_act;

	wire on = ctrl[`SPF_BIT_ON];
	wire audio = ctrl[`SPF_BIT_AUDIO];
	wire wide = ctrl[`SPF_BIT_WIDE];
	wire mid = ctrl[`SPF_BIT_MID];
	wire master = ctrl[`SPF_BIT_MASTER];
	wire cke = ctrl[`SPF_BIT_CKE];
	// Framed operation ignores the edge bit; software is expected to keep it zero
	wire eff_cke = cke && !ctrl[`SPF_BIT_FRAMED];
	wire pol = audio | ctrl[`SPF_BIT_POL];

	// ----------------------------------------
	// Word, channel and sample widths
	// ----------------------------------------
	reg [6:0] unit_len;
	reg [6:0] sample_len;
	always @* begin
		if (audio) begin
			unit_len = (wide || mid) ? 7'd32 : 7'd16;
			sample_len = wide ? (mid ? 7'd24 : 7'd32) : 7'd16;
		end else begin
			unit_len = wide ? 7'd32 : (mid ? 7'd16 : 7'd8);
			sample_len = unit_len;
		end
	end

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [31:0] fifo_out_data;
	wire wr_go = aw_held && w_held && !s_axi_bvalid;
	wire wr_tx = wr_go && (aw_addr == `SPF_OFS_TXDATA);
	// A data write to a full FIFO waits, holding the response back
	wire wr_do = wr_go && (!wr_tx || fifo_in_ready);
	wire rd_do = s_axi_arvalid && !s_axi_rvalid;
	wire rd_rx = rd_do && (s_axi_araddr == `SPF_OFS_RXDATA);
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !s_axi_rvalid;

	// Strobe-merged write value for the control register
	wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire [31:0] ctrl_wr = (w_data & strb_mask) | (ctrl & ~strb_mask);
	// Width bits keep their value while the port runs
	wire [31:0] ctrl_keep = ((32'h1 << `SPF_BIT_WIDE) | (32'h1 << `SPF_BIT_MID)) & {32{on}};
	wire [31:0] ctrl_new = ((ctrl_wr & ~ctrl_keep) | (ctrl & ctrl_keep)) & `SPF_CTRL_MASK;

	// Address and data are latched separately, in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 5'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SPF_RESP_OKAY;
			ctrl <= `SPF_CTRL_RESET;
			baud <= `SPF_BAUD_RESET;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_do) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `SPF_RESP_OKAY;
				case (aw_addr)
				`SPF_OFS_CTRL: ctrl <= ctrl_new;
				`SPF_OFS_BAUD: baud <= ctrl_wr[15:0];
				`SPF_OFS_TXDATA, `SPF_OFS_STATUS, `SPF_OFS_RXDATA: ;
				default: s_axi_bresp <= `SPF_RESP_SLVERR;
				endcase
			end
		end
	end

	// Read answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SPF_RESP_OKAY;
		end else if (rd_do) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `SPF_RESP_OKAY;
			case (s_axi_araddr)
			`SPF_OFS_CTRL: s_axi_rdata <= ctrl;
			`SPF_OFS_BAUD: s_axi_rdata <= {16'h0000, baud};
			`SPF_OFS_RXDATA: s_axi_rdata <= rx_data;
			`SPF_OFS_STATUS: s_axi_rdata <= {26'h0000000, word_select, busy, rx_ovf,
				rx_full, !fifo_in_ready, !fifo_out_valid};
			`SPF_OFS_TXDATA: s_axi_rdata <= 32'h00000000;
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `SPF_RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Third clock stage serves only the edge detector
	always @(posedge aclk) begin
		if (!aresetn) begin
			sclk_s <= 3'h0;
			sdi_s <= 2'h0;
			ss_s <= 2'h3;
		end else begin
			sclk_s <= {sclk_s[1:0], sclk_i};
			sdi_s <= {sdi_s[0], sdi};
			ss_s <= {ss_s[0], slave_select_pin_n};
		end
	end

	// ----------------------------------------
	// Serial engine strobes
	// ----------------------------------------
	wire [6:0] two_n = {unit_len[5:0], 1'b0};
	wire [6:0] t_next = t_cnt + 7'd1;
	wire m_tick = busy && master && (div_cnt == 16'h0000);
	wire m_lead = t_next[0];
	// Middle falls on the edge opposite the change edge
	wire m_mid = m_tick && (eff_cke ? m_lead : !m_lead) && (t_next <= two_n);
	wire m_end = m_tick && (eff_cke ? !m_lead : (m_lead && t_next > 7'd1));
	wire s_lead = (sclk_s[1] != pol) && (sclk_s[2] == pol);
	wire s_trail = (sclk_s[1] == pol) && (sclk_s[2] != pol);
	wire s_mid = busy && !master && (eff_cke ? s_lead : s_trail);
	// When output changes idle-to-active, the first change edge of a slave word only presents the already loaded bit
	wire s_chg = busy && !master && (eff_cke ? s_trail : s_lead) && (bit_cnt != 6'd0);
	wire phase_end = ctrl[`SPF_BIT_PHASE] && master;
	wire do_sample = (master ? (phase_end ? m_end : m_mid) : s_mid)
		&& ({1'b0, bit_cnt} < unit_len);
	wire do_shift = master ? m_end : s_chg;
	wire [31:0] rx_next = {rx_sh[30:0], sdi_s[1]};
	wire [5:0] bits_after = bit_cnt + {5'd0, do_sample};
	wire last_bit = do_sample && ({1'b0, bits_after} == unit_len);
	wire m_done = m_tick && (t_next >= two_n) && ({1'b0, bits_after} == unit_len);
	wire unit_done = master ? m_done : last_bit;
	wire ss_ok = !ctrl[`SPF_BIT_SSUSE] || !ss_s[1];
	wire m_start = on && master && !busy && fifo_out_valid;
	wire s_start = on && !master && !busy && ss_ok;
	wire s_abort = busy && !master && !ss_ok;
	wire fifo_pop = m_start || (s_start && fifo_out_valid);
	wire [5:0] pad = 6'd32 - sample_len[5:0];
	wire [31:0] tx_load = fifo_out_valid ? (fifo_out_data << pad) : 32'h00000000;

	spf_fifo #(
		.WIDTH(32),
		.DEPTH(32),
		.AW(5)
	) u_txfifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.flush(!on),
		.in_data(w_data),
		.in_valid(wr_tx),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop)
	);

	// ----------------------------------------
	// Shift engine
	// ----------------------------------------
	// Switching the port off drops any word in flight
	always @(posedge aclk) begin
		if (!aresetn || !on) begin
			busy <= 1'b0;
			t_cnt <= 7'd0;
			bit_cnt <= 6'd0;
			div_cnt <= 16'h0000;
			tx_sh <= 32'h00000000;
			rx_sh <= 32'h00000000;
			sclk_act <= 1'b0;
		end else if (m_start || s_start) begin
			busy <= 1'b1;
			t_cnt <= 7'd0;
			bit_cnt <= 6'd0;
			div_cnt <= baud;
			tx_sh <= tx_load;
			sclk_act <= 1'b0;
		end else if (s_abort) begin
			busy <= 1'b0;
		end else if (busy) begin
			if (master)
				div_cnt <= (div_cnt == 16'h0000) ? baud : div_cnt - 16'h0001;
			if (m_tick) begin
				t_cnt <= t_next;
				if (t_next <= two_n)
					sclk_act <= !sclk_act;
			end
			if (do_sample) begin
				bit_cnt <= bits_after;
				if ({1'b0, bit_cnt} < sample_len)
					rx_sh <= rx_next;
			end
			if (do_shift)
				tx_sh <= {tx_sh[30:0], 1'b0};
			if (unit_done)
				busy <= 1'b0;
		end
	end

	// Only sample bits reach the receive word; padding bits are dropped
	wire [31:0] rx_word = ({1'b0, bit_cnt} < sample_len) ? rx_next : rx_sh;

	// Receive holding register; a new word beats a read in the same cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_data <= 32'h00000000;
			rx_full <= 1'b0;
			rx_ovf <= 1'b0;
			word_select <= 1'b0;
		end else begin
			if (rd_rx)
				rx_full <= 1'b0;
			if (wr_do && aw_addr == `SPF_OFS_STATUS && w_strb[0] && w_data[`SPF_ST_RXOVF])
				rx_ovf <= 1'b0;
			if (busy && unit_done) begin
				rx_data <= rx_word;
				rx_full <= 1'b1;
				if (rx_full && !rd_rx)
					rx_ovf <= 1'b1;
				word_select <= audio ? !word_select : 1'b0;
			end else if (!audio) begin
				word_select <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------
	// Slave leaves the clock pin undriven and follows the peer
	always @(posedge aclk) begin
		if (!aresetn) begin
			sclk_o <= 1'b0;
			sclk_oe_n <= 1'b1;
			sdo <= 1'b0;
		end else begin
			sclk_o <= sclk_act ? !pol : pol;
			sclk_oe_n <= !(on && master);
			sdo <= tx_sh[31];
		end
	end
endmodule

// File: dv/spf_chk.sv
// Checker for the serial port slice: bus handshakes, clock pin role, channel flag.
// Sees top ports only; control bits are shadowed from whole-word bus writes.
// Assumes the transmit FIFO never fills, so every write answers two edges on.
`timescale 1ns/1ps
module spf_chk (
	input wire aclk,
	input wire aresetn,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire sclk_oe_n,
	input wire word_select
);
	logic [31:0] ctl;
	wire onm = ctl[15] && ctl[5];
	wire aud = ctl[30];
	// ----------------------------------------
	// Control shadow
	// ----------------------------------------
	// Only on, role and audio bits are used; those are always writable
	always @(posedge aclk) begin
		if (!aresetn)
			ctl <= '0;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == 5'h00)
			ctl <= s_axi_wdata;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	AST_BRISE: assert property (s_wr |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	AST_RLAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer unstable");
	AST_BONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	AST_OEON: assert property (onm [*3] |-> !sclk_oe_n)
		else $error("master not driving clock");
	AST_OEOFF: assert property (!onm [*3] |-> sclk_oe_n)
		else $error("clock driven outside master role");
	AST_WSOFF: assert property (!aud [*3] |-> !word_select)
		else $error("channel flag in plain mode");
endmodule
bind spf_serial_port spf_chk u_chk (.*);

// File: dv/spf_peer.sv
// Far-side serial peer: slave to a master port, master to a slave port.
// Output changes on the falling clock edge and is sampled on the rising one.
`timescale 1ns/1ps
module spf_peer (
	input wire sclk_o,
	input wire sdo,
	output logic sclk_i,
	output logic sdi,
	output logic ss_n
);
	logic [31:0] word = 32'h3c5a96e1;
	logic [31:0] got = '0;
	logic [4:0] idx = '0;
	logic slv = 1'b0;
	logic sbit = 1'b0;
	int nedge = 0;
	// Clock and select rest idle between frames
	initial begin
		sclk_i = 1'b0;
		ss_n = 1'b1;
	end
	// Data follows the port's clock unless this side runs the frame
	assign sdi = slv ? sbit : word[5'd31 - idx];
	// Sample at the middle of the bit, count clock pulses
	always @(posedge sclk_o) begin
		got <= {got[30:0], sdo};
		nedge <= nedge + 1;
	end
	// Next bit on each falling clock edge
	always @(negedge sclk_o)
		idx <= idx + 5'd1;
	// Idle-high clock falls first, so the first bit comes with that edge
	task clear(input logic lead);
		got = '0;
		nedge = 0;
		idx = lead ? 5'h1f : 5'h00;
	endtask
	// Run a frame as master at 80 ns per bit; sel low keeps select high
	task frame(input int n, input logic sel);
		int k;
		slv = 1'b1;
		ss_n = !sel;
		for (k = 0; k < n; k++) begin
			sbit = word[31 - k];
			#40 sclk_i = 1'b1;
			#40 sclk_i = 1'b0;
		end
		ss_n = 1'b1;
		sbit = ~sbit; // Released line must not keep the last bit
		slv = 1'b0;
	endtask
endmodule

// File: dv/tb.sv
// Testbench for the serial port slice: registers, word widths, roles.
// Assumes the peer model on the serial pins; every wait is bounded.
`timescale 1ns/1ps
module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [4:0] s_axi_awaddr = '0;
	logic [4:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire sclk_i, sclk_o, sclk_oe_n, sdi, sdo, slave_select_pin_n, word_select;
	logic [31:0] rd;
	logic [31:0] m;
	logic [1:0] rs;
	int fail_count = 0;
	int total_checks = 0;
	// Rows: control word, bits per master word
	logic [31:0] mc [6] = '{32'h00008320, 32'h00008120, 32'h00008520, 32'h40008020,
		32'h00008920, 32'h00008d20};
	int mn [6] = '{8, 8, 16, 16, 32, 32};
	// Rows: control word, clock level while idle
	logic [31:0] ic [3] = '{32'h00008020, 32'h00008060, 32'h40008020};
	logic il [3] = '{1'b0, 1'b1, 1'b1};
	// Free-running 100 MHz clock
	always #5 aclk = ~aclk;
	spf_serial_port dut (.*);
	spf_peer peer (.sclk_o(sclk_o), .sdo(sdo), .sclk_i(sclk_i), .sdi(sdi),
		.ss_n(slave_select_pin_n));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task results;
		if (fail_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task tmo(input int i);
		if (i >= 500) begin
			fail_count++;
			results();
		end
	endtask
	// Address and data offered together, held until taken
	task wr(input logic [4:0] a, input logic [31:0] d);
		int i;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		i = 0;
		// Each channel is released at the edge that takes it
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && ++i < 500);
		tmo(i);
		s_axi_bready <= 1'b0;
		// One idle edge keeps the next call from re-raising bready at once
		@(posedge aclk);
	endtask
	task rdx(input logic [4:0] a);
		int i;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		i = 0;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && ++i < 500);
		tmo(i);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	// Poll status until the transmit side is empty and not busy
	task idle;
		int i;
		i = 0;
		do rdx(5'h0c); while (!(rd[4] === 1'b0 && rd[0] === 1'b1) && ++i < 500);
		tmo(i);
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		int j;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdx(5'h00);
		chk("ctrl reset", 32'h00000000, rd);
		wr(5'h10, 32'h00000007);
		for (j = 0; j < 6; j++) begin
			wr(5'h00, 32'h00000000);
			wr(5'h00, mc[j]);
			rdx(5'h00);
			chk("ctrl", mc[j], rd);
			peer.clear(mc[j][6] | mc[j][30]);
			wr(5'h04, 32'hc3a55a0f);
			idle();
			m = 32'hffffffff >> (32 - mn[j]);
			chk("pulses", mn[j], peer.nedge);
			chk("sent", 32'hc3a55a0f & m, peer.got & m);
			rdx(5'h08);
			chk("received", peer.word >> (32 - mn[j]), rd);
			chk("channel", mc[j][30], word_select);
		end
		wr(5'h00, 32'h00008120);
		rdx(5'h00);
		chk("width locked", 32'h00008d20, rd);
		wr(5'h00, 32'h00000000);
		rdx(5'h00);
		chk("width kept", 32'h00000c00, rd);
		wr(5'h00, 32'hffff7eff);
		rdx(5'h00);
		chk("ctrl fields", 32'hc0000ee0, rd);
		for (j = 0; j < 3; j++) begin
			wr(5'h00, 32'h00000000);
			wr(5'h00, ic[j]);
			rdx(5'h0c);
			@(negedge aclk);
			chk("idle level", il[j], sclk_o);
			@(posedge aclk);
		end
		wr(5'h00, 32'h00000000);
		wr(5'h00, 32'h00008380);
		rdx(5'h08);
		peer.frame(8, 1'b1);
		@(posedge aclk);
		rdx(5'h08);
		chk("slave rx", 32'h0000003c, rd);
		peer.frame(8, 1'b0);
		@(posedge aclk);
		rdx(5'h0c);
		chk("deselected", 1'b0, rd[2]);
		// Reset in mid-run must drop the configuration
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdx(5'h00);
		chk("ctrl after reset", 32'h00000000, rd);
		chk("clock drive after reset", 32'h00000001, sclk_oe_n);
		rdx(5'h14);
		chk("unmapped resp", 2'b10, rs);
		chk("unmapped data", 32'h00000000, rd);
		results();
	end
endmodule
